/* design/blk_search_exec.v */
// Execution unit for prefixed block move and byte search instructions
`timescale 1ns/1ps
`include "blk_search_defines.vh"

module blk_search_exec (
  input wire clock_i,
  input wire rst_n_i,
  input wire [3:0] addr_i,
  input wire [15:0] wr_data_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rd_data_o,
  input wire [7:0] mem_rdata_i,
  output reg [15:0] mem_addr_o,
  output reg [7:0] mem_wdata_o,
  output reg mem_rd_o,
  output reg mem_wr_o,
  output reg refresh_o,
  input wire int_req_i,
  output reg int_ack_o,
  output reg busy_o
);

  // ---------------------------------------------------------------
  // States, one per machine cycle
  // ---------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_FETCH1 = 3'd1;
  localparam [2:0] ST_FETCH2 = 3'd2;
  localparam [2:0] ST_READ = 3'd3;
  localparam [2:0] ST_EXEC = 3'd4;
  localparam [2:0] ST_REP = 3'd5;

  // Sequencer position and T state bookkeeping
  reg [2:0] state_q;
  reg [4:0] t_q;
  reg [4:0] tstates_q;
  reg [4:0] last_tstates_q;

  // Architectural registers seen by software
  reg [15:0] src_q;
  reg [15:0] tgt_q;
  reg [15:0] cnt_q;
  reg [15:0] pc_q;
  reg [7:0] acc_q;
  reg [7:0] flags_q;

  // Opcode and operand latches
  reg [7:0] op1_q;
  reg [7:0] op2_q;
  reg [7:0] data_q;

  // Status bits, cleared by the next start
  reg done_q;
  reg bad_op_q;
  reg int_taken_q;

  // Two-stage request synchroniser
  reg int_meta_q;
  reg int_sync_q;

  // Next values, decode and read select
  wire [15:0] cnt_new;
  wire [15:0] src_new;
  wire [15:0] tgt_new;
  wire [7:0] flags_new;
  wire match;
  wire is_search;
  wire is_repeat;
  wire is_down;
  wire op_valid;
  wire last_t;
  reg [4:0] len;
  reg [15:0] rd_data_d;

  // ---------------------------------------------------------------
  // Decode of the second opcode byte
  // ---------------------------------------------------------------
  assign is_search = op2_q[0];
  assign is_repeat = op2_q[4];
  assign is_down = op2_q[3];
  assign op_valid = (op1_q == `OP_PREFIX) &&
    ((op2_q == `OP_MOVE_DOWN_ONCE) || (op2_q == `OP_MOVE_DOWN_REPEAT) ||
     (op2_q == `OP_SEARCH_UP_ONCE) || (op2_q == `OP_SEARCH_UP_REPEAT) ||
     (op2_q == `OP_SEARCH_DOWN_ONCE) ||
     (op2_q == `OP_SEARCH_DOWN_REPEAT));

  // 16-bit wrapping steps; a zero count wraps to all ones
  assign cnt_new = cnt_q - 16'h0001;
  assign src_new = is_down ? (src_q - 16'h0001) : (src_q + 16'h0001);
  assign tgt_new = tgt_q - 16'h0001;

  // Machine cycle length for the current state
  always @* begin
    case (state_q)
      ST_FETCH1: len = `LEN_FETCH1;
      ST_FETCH2: len = `LEN_FETCH2;
      ST_READ: len = `LEN_READ;
      ST_EXEC: len = `LEN_EXEC;
      ST_REP: len = `LEN_REP;
      default: len = 5'd1;
    endcase
  end
  // Last T state of the current machine cycle
  assign last_t = (t_q == (len - 5'd1));

  // Flags are merged combinationally and latched with the pointers
  flag_unit u_flags (
    .acc_i(acc_q),
    .data_i(data_q),
    .cnt_new_i(cnt_new),
    .search_i(is_search),
    .flags_i(flags_q),
    .flags_o(flags_new),
    .match_o(match)
  );

  // ---------------------------------------------------------------
  // Interrupt request synchroniser
  // ---------------------------------------------------------------
  // The request pin is asynchronous to the core clock
  // Only the second stage is read by the sequencer
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_meta_q <= 1'b0;
      int_sync_q <= 1'b0;
    end else begin
      int_meta_q <= int_req_i;
      int_sync_q <= int_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer and architectural registers
  // ---------------------------------------------------------------
  // Software may only load registers while idle, so a running
  // instruction never sees its operands change under it.
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Sequencer back to idle
      state_q <= ST_IDLE;
      t_q <= 5'd0;
      tstates_q <= 5'd0;
      last_tstates_q <= 5'd0;
      // Architectural registers
      src_q <= `RST_WORD;
      tgt_q <= `RST_WORD;
      cnt_q <= `RST_WORD;
      pc_q <= `RST_WORD;
      acc_q <= 8'h00;
      flags_q <= `RST_FLAGS;
      // Latches and status
      op1_q <= 8'h00;
      op2_q <= 8'h00;
      data_q <= 8'h00;
      done_q <= 1'b0;
      bad_op_q <= 1'b0;
      int_taken_q <= 1'b0;
      // Bus outputs rest low
      mem_addr_o <= `RST_WORD;
      mem_wdata_o <= 8'h00;
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      refresh_o <= 1'b0;
      int_ack_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      // Strobes are one-cycle pulses unless a state raises them
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      refresh_o <= 1'b0;
      int_ack_o <= 1'b0;
      // One T state per clock while an instruction runs
      if (state_q != ST_IDLE) begin
        t_q <= last_t ? 5'd0 : (t_q + 5'd1);
        tstates_q <= tstates_q + 5'd1;
      end
      case (state_q)
        // Idle: software loads registers or starts an instruction
        ST_IDLE: begin
          if (wr_i) begin
            case (addr_i)
              `REG_CTRL: begin
                // Start clears last status and fetches the prefix at PC
                if (wr_data_i[0]) begin
                  state_q <= ST_FETCH1;
                  t_q <= 5'd0;
                  tstates_q <= 5'd0;
                  mem_addr_o <= pc_q;
                  mem_rd_o <= 1'b1;
                  busy_o <= 1'b1;
                  done_q <= 1'b0;
                  bad_op_q <= 1'b0;
                  int_taken_q <= 1'b0;
                end
              end
              `REG_SRC: src_q <= wr_data_i;
              `REG_TGT: tgt_q <= wr_data_i;
              `REG_CNT: cnt_q <= wr_data_i;
              `REG_ACC: acc_q <= wr_data_i[7:0];
              `REG_FLAGS: flags_q <= wr_data_i[7:0];
              `REG_PC: pc_q <= wr_data_i;
              default: ;
            endcase
          end
        end
        // Prefix byte, captured one cycle after its read strobe
        ST_FETCH1: begin
          if (t_q == 5'd1) begin
            op1_q <= mem_rdata_i;
          end
          if (last_t) begin
            pc_q <= pc_q + 16'h0001;
            mem_addr_o <= pc_q + 16'h0001;
            mem_rd_o <= 1'b1;
            state_q <= ST_FETCH2;
          end
        end
        // Second opcode byte; the pair is checked on the last T state
        ST_FETCH2: begin
          if (t_q == 5'd1) begin
            op2_q <= mem_rdata_i;
          end
          if (last_t) begin
            pc_q <= pc_q + 16'h0001;
            if (op_valid) begin
              mem_addr_o <= src_q;
              mem_rd_o <= 1'b1;
              state_q <= ST_READ;
            end else begin
              // Unknown pairs stop here and are reported, not executed
              bad_op_q <= 1'b1;
              busy_o <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        // Operand read; moves launch their write in the next cycle
        ST_READ: begin
          if (t_q == 5'd1) begin
            data_q <= mem_rdata_i;
          end
          if (last_t) begin
            state_q <= ST_EXEC;
            // Searches only read; nothing is written back
            if (!is_search) begin
              mem_addr_o <= tgt_q;
              mem_wdata_o <= data_q;
              mem_wr_o <= 1'b1;
            end
          end
        end
        // Internal cycle; register updates land on its last T state
        ST_EXEC: begin
          if (last_t) begin
            src_q <= src_new;
            cnt_q <= cnt_new;
            flags_q <= flags_new;
            // Only moves step the target pointer
            if (!is_search) begin
              tgt_q <= tgt_new;
            end
            // Repeat unless count hits zero or a search matches
            if (is_repeat && (cnt_new != 16'h0000) &&
                !(is_search && match)) begin
              // Rewind points the next fetch back at the prefix byte
              pc_q <= pc_q - 16'h0002;
              state_q <= ST_REP;
            end else begin
              last_tstates_q <= tstates_q + 5'd1;
              done_q <= 1'b1;
              busy_o <= 1'b0;
              state_q <= ST_IDLE;
            end
          end
        end
        ST_REP: begin
          // Two refresh cycles after each byte that does not end the instruction
          if ((t_q == 5'd1) || (t_q == 5'd2)) begin
            mem_addr_o <= pc_q;
            refresh_o <= 1'b1;
          end
          if (last_t) begin
            last_tstates_q <= tstates_q + 5'd1;
            if (int_sync_q) begin
              // PC is already rewound, so the loop resumes later
              int_ack_o <= 1'b1;
              int_taken_q <= 1'b1;
              busy_o <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              // No request pending: fetch the prefix again
              t_q <= 5'd0;
              tstates_q <= 5'd0;
              mem_addr_o <= pc_q;
              mem_rd_o <= 1'b1;
              state_q <= ST_FETCH1;
            end
          end
        end
        // Unused state codes fall back to idle
        default: begin
          state_q <= ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register read port, data one cycle after the strobe
  // ---------------------------------------------------------------
  // Select is combinational so the output stays a bare flop; a cycle
  // without a read strobe returns zero rather than stale data.
  always @* begin
    rd_data_d = 16'h0000;
    if (rd_i) begin
      case (addr_i)
        `REG_STATUS: rd_data_d = {12'h000, int_taken_q, bad_op_q,
          done_q, busy_o};
        `REG_SRC: rd_data_d = src_q;
        `REG_TGT: rd_data_d = tgt_q;
        `REG_CNT: rd_data_d = cnt_q;
        `REG_ACC: rd_data_d = {8'h00, acc_q};
        `REG_FLAGS: rd_data_d = {8'h00, flags_q};
        `REG_PC: rd_data_d = pc_q;
        `REG_TSTATES: rd_data_d = {11'h000, last_tstates_q};
        default: rd_data_d = 16'h0000;
      endcase
    end
  end

  // Output register for the read data
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= rd_data_d;
    end
  end

endmodule

/* design/blk_search_defines.vh */
// Constants for the block move and search execution unit
`ifndef BLK_SEARCH_DEFINES_VH
`define BLK_SEARCH_DEFINES_VH

// Register indices on the software port
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_SRC 4'h2
`define REG_TGT 4'h3
`define REG_CNT 4'h4
`define REG_ACC 4'h5
`define REG_FLAGS 4'h6
`define REG_PC 4'h7
`define REG_TSTATES 4'h8

// Flag bit positions
`define FLAG_S 7
`define FLAG_Z 6
`define FLAG_H 4
`define FLAG_PV 2
`define FLAG_N 1
`define FLAG_C 0

// Opcodes
`define OP_PREFIX 8'hED
`define OP_MOVE_DOWN_ONCE 8'hA8
`define OP_MOVE_DOWN_REPEAT 8'hB8
`define OP_SEARCH_UP_ONCE 8'hA1
`define OP_SEARCH_UP_REPEAT 8'hB1
`define OP_SEARCH_DOWN_ONCE 8'hA9
`define OP_SEARCH_DOWN_REPEAT 8'hB9

// Machine cycle lengths in T states, one T state per clock
`define LEN_FETCH1 5'd4
`define LEN_FETCH2 5'd4
`define LEN_READ 5'd3
`define LEN_EXEC 5'd5
`define LEN_REP 5'd5

// Reset values
`define RST_FLAGS 8'h00
`define RST_WORD 16'h0000

`endif

/* design/flag_unit.v */
// Flag computation for block moves and searches
`timescale 1ns/1ps
`include "blk_search_defines.vh"

module flag_unit (
  input wire [7:0] acc_i,
  input wire [7:0] data_i,
  input wire [15:0] cnt_new_i,
  input wire search_i,
  input wire [7:0] flags_i,
  output reg [7:0] flags_o,
  output wire match_o
);

  wire [8:0] diff;
  wire [4:0] low_diff;

  // Difference only drives flags, nothing stores it
  assign diff = {1'b0, acc_i} - {1'b0, data_i};
  assign low_diff = {1'b0, acc_i[3:0]} - {1'b0, data_i[3:0]};
  assign match_o = (acc_i == data_i);

  // -------------------------------------------------------------
  // Flag merge
  // -------------------------------------------------------------
  always @* begin
    flags_o = flags_i;
    flags_o[`FLAG_H] = 1'b0;
    flags_o[`FLAG_N] = 1'b0;
    // Count reaching zero on the last repeat leaves P/V clear
    flags_o[`FLAG_PV] = (cnt_new_i != 16'h0000);
    if (search_i) begin
      flags_o[`FLAG_S] = diff[7];
      flags_o[`FLAG_Z] = match_o;
      flags_o[`FLAG_H] = low_diff[4];
      flags_o[`FLAG_N] = 1'b1;
    end
  end

endmodule

/* tb/mem_model.sv */
// Behavioural system memory facing the execution unit
`timescale 1ns/1ps
module mem_model (
  input wire clock_i,
  input wire [15:0] addr_i,
  input wire [7:0] wdata_i,
  input wire rd_i,
  input wire wr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  initial rdata_o = 8'h5A;
  // Read data stand one cycle, then the bus toggles so late samples fail
  always @(posedge clock_i) begin
    if (rd_i) begin
      rdata_o <= mem[addr_i];
    end else begin
      rdata_o <= ~rdata_o;
    end
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule

/* tb/blk_search_exec_properties.sv */
// Port-level checks for the block move and search execution unit
`timescale 1ns/1ps
module blk_search_exec_properties (
  input wire clock_i,
  input wire rst_n_i,
  input wire [7:0] mem_rdata_i,
  input wire [7:0] mem_wdata_o,
  input wire mem_rd_o,
  input wire mem_wr_o,
  input wire refresh_o,
  input wire int_req_i,
  input wire int_ack_o,
  input wire busy_o
);
  int bcnt_q;
  logic [3:0] rf_age_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Busy length and age of the last refresh; age saturates to stay small
  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bcnt_q <= 0;
      rf_age_q <= 4'hF;
    end else begin
      bcnt_q <= busy_o ? bcnt_q + 1 : 0;
      rf_age_q <= refresh_o ? 4'h0 : rf_age_q + {3'h0, rf_age_q != 4'hF};
    end
  end
  chk_refresh_pair: assert property (
    $rose(refresh_o) |=> refresh_o ##1 !refresh_o)
    else $error("refresh not two cycles");
  chk_refresh_busy: assert property (
    refresh_o |-> busy_o) else $error("refresh while idle");
  chk_mem_busy: assert property (
    (mem_rd_o || mem_wr_o) |-> busy_o) else $error("access while idle");
  chk_fetch_gap: assert property (
    $rose(busy_o) |-> mem_rd_o ##4 mem_rd_o) else $error("fetch spacing");
  chk_write_after: assert property (
    mem_wr_o |-> $past(mem_rd_o, 3)) else $error("write not after read");
  chk_write_data: assert property (
    mem_wr_o |-> mem_wdata_o == $past(mem_rdata_i, 2))
    else $error("write data not read data");
  chk_busy_len: assert property (
    $fell(busy_o) |-> (bcnt_q % 21 == 16 || bcnt_q % 21 == 0 || bcnt_q == 8))
    else $error("instruction length");
  chk_rep_next: assert property (
    $fell(refresh_o) |-> ##[0:3] (mem_rd_o || !busy_o))
    else $error("no refetch after refresh");
  chk_ack_refresh: assert property (
    int_ack_o |-> rf_age_q < 4'h8 && $past(int_req_i, 2))
    else $error("acknowledge outside gap");
endmodule

bind blk_search_exec blk_search_exec_properties chk_u (.clock_i, .rst_n_i,
  .mem_rdata_i, .mem_wdata_o, .mem_rd_o, .mem_wr_o, .refresh_o, .int_req_i,
  .int_ack_o, .busy_o);

/* tb/test_block_move_search_exec.sv */
// Self-checking bench for the block move and search execution unit
`timescale 1ns/1ps
`include "blk_search_defines.vh"
module test_block_move_search_exec;
  logic clock_i, rst_n_i, wr_i, rd_i, int_req_i;
  logic [3:0] addr_i;
  logic [15:0] wr_data_i;
  wire [15:0] rd_data_o, mem_addr_o;
  wire [7:0] mem_rdata_i, mem_wdata_o;
  wire mem_rd_o, mem_wr_o, refresh_o, int_ack_o, busy_o;
  logic [7:0] em [0:65535];
  logic [7:0] ops [0:5] = '{8'hA8, 8'hB8, 8'hA1, 8'hB1, 8'hA9, 8'hB9};
  int err_count = 0, n_checks = 0, acks = 0;

  blk_search_exec DUT (.clock_i, .rst_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
    .rd_data_o, .mem_rdata_i, .mem_addr_o, .mem_wdata_o, .mem_rd_o,
    .mem_wr_o, .refresh_o, .int_req_i, .int_ack_o, .busy_o);
  mem_model mem_u (.clock_i(clock_i), .addr_i(mem_addr_o),
    .wdata_i(mem_wdata_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
    .rdata_o(mem_rdata_i));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  always @(posedge clock_i) acks <= acks + int_ack_o;

  // ----------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------
  task cmp(input string n, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task rdc(input logic [3:0] a, input logic [15:0] e, input string n);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 cmp(n, e, rd_data_o);
  endtask
  function automatic logic [7:0] fl_s(input logic [7:0] a, b, f,
                                      input logic [15:0] c);
    logic [7:0] d;
    d = a - b;
    return {d[7], a == b, 1'b0, a[3:0] < b[3:0], 1'b0, c != 0, 1'b1, f[0]};
  endfunction
  function automatic logic [7:0] fl_m(input logic [7:0] f,
                                      input logic [15:0] c);
    return {f[7:6], 3'b000, c != 0, 1'b0, f[0]};
  endfunction

  // One instruction: irq stops a repeat after its first pass
  task run(input logic [7:0] op, input int k, input logic irq);
    logic [15:0] s, t, c, s0, t0, c0, pc;
    logic [7:0] a, f, f0, b;
    int n, tc, a0;
    n = 0;
    tc = 0;
    s0 = k == 6 ? 16'h0000 : k == 8 ? 16'hFFFF : 16'h3000 + $urandom % 2048;
    t0 = k == 12 ? 16'h0000 : 16'h9000 + $urandom % 2048;
    c0 = k >= 18 ? 16'h0000 : (k == 1 || k == 5) ? 16'h0001 :
      16'($urandom_range(2, 5));
    a = $urandom;
    f0 = $urandom & 8'hD7;
    pc = 16'h0100 + 16'(2 * k);
    for (int j = -6; j <= 6; j++)
      mem_u.mem[16'(s0 + j)] = $urandom;
    if (k / 6 == 1)
      mem_u.mem[op[3] ? s0 - 16'h1 : s0 + 16'h1] = a;
    if (irq)
      mem_u.mem[s0] = ~a;
    mem_u.mem[pc] = `OP_PREFIX;
    mem_u.mem[pc + 16'h1] = op;
    em = mem_u.mem;
    s = s0;
    t = t0;
    c = c0;
    f = f0;
    do begin
      b = em[s];
      c = c - 16'h1;
      n++;
      if (op[0]) begin
        f = fl_s(a, b, f, c);
        s = op[3] ? s - 16'h1 : s + 16'h1;
      end else begin
        em[t] = b;
        t = t - 16'h1;
        s = s - 16'h1;
        f = fl_m(f, c);
      end
    end while (op[4] && c != 0 && !(op[0] && f[6]) && !irq);
    wr(`REG_SRC, s0);
    wr(`REG_TGT, t0);
    wr(`REG_CNT, c0);
    wr(`REG_ACC, {8'h00, a});
    wr(`REG_FLAGS, {8'h00, f0});
    wr(`REG_PC, pc);
    a0 = acks;
    int_req_i <= irq;
    wr(`REG_CTRL, 16'h0001);
    for (int w = 0; w < 3000 && (tc == 0 || busy_o === 1'b1); w++) begin
      #1;
      if (busy_o === 1'b1)
        tc++;
      @(posedge clock_i);
    end
    int_req_i <= 1'b0;
    cmp("cycles", irq ? 16'd21 : 16'(21 * n - 5), 16'(tc));
    rdc(`REG_SRC, s, "source");
    rdc(`REG_TGT, t, "target");
    rdc(`REG_CNT, c, "count");
    rdc(`REG_ACC, {8'h00, a}, "accumulator");
    rdc(`REG_FLAGS, {8'h00, f}, "flags");
    rdc(`REG_PC, irq ? pc : pc + 16'h2, "pc");
    rdc(`REG_STATUS, irq ? 16'h0008 : 16'h0002, "status");
    if (!irq)
      rdc(`REG_TSTATES, 16'h0010, "t states");
    if (irq)
      cmp("acknowledge", 16'h0001, 16'(acks - a0));
    for (int j = -6; j <= 6; j++)
      cmp("memory", em[16'(t0 + j)], mem_u.mem[16'(t0 + j)]);
    $display("test %0d opcode %h done", k, op);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    int_req_i = 1'b0;
    addr_i = 4'h0;
    wr_data_i = 16'h0000;
    void'($urandom(13203));
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rdc(`REG_FLAGS, {8'h00, `RST_FLAGS}, "reset flags");
    rdc(4'hC, 16'h0000, "unmapped");
    for (int k = 0; k < 18; k++)
      run(ops[k % 6], k, 1'b0);
    run(8'hB8, 18, 1'b1);
    run(8'hB9, 19, 1'b1);
    // Unsupported second byte stops after both fetches; loads refused
    mem_u.mem[16'h0200] = `OP_PREFIX;
    mem_u.mem[16'h0201] = 8'hA0;
    wr(`REG_SRC, 16'h1234);
    wr(`REG_PC, 16'h0200);
    wr(`REG_CTRL, 16'h0001);
    wr(`REG_SRC, 16'hABCD);
    repeat (10) @(posedge clock_i);
    rdc(`REG_STATUS, 16'h0004, "bad opcode status");
    rdc(`REG_PC, 16'h0202, "bad opcode pc");
    rdc(`REG_SRC, 16'h1234, "source while busy");
    $display("test bad opcode done");
    test_done;
  end
  // Runs take well under half a millisecond; this only cuts a hang
  initial begin
    #5000000;
    err_count++;
    $display("unexpected watchdog expected done seen timeout");
    test_done;
  end
endmodule
